// >>> core/low_power_mode_controller.sv
// Low-power mode controller: mode state machine, clock gating, pin states
`timescale 1ns/100ps
module low_power_mode_controller
   import lpm_pkg::*;
#(
   parameter int NP = 12,
   parameter int NPIN = 8
)(
   input wire logic mclk,
   input wire logic rst_b,
   lpm_link_if.dev_mp link,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NPIN-1:0] pin_in,
   input wire logic [WK_N-1:0] wake_src,
   input wire logic dbg_sel,
   input wire logic dbg_out_valid,
   output logic [NP-1:0] periph_clk_en,
   output logic lvd_clk_en,
   output logic i2c_wake_en,
   output logic usb_wake_en,
   output logic int_osc_en,
   output logic ext_osc_en,
   output logic sys_clk_sel_ext,
   output logic crystal_valid,
   output logic wdt_clear_allow,
   output logic [NPIN-1:0] pin_in_valid,
   output logic [NPIN-1:0] pin_oe_b,
   output logic dbg_oe_b
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int SW = NPIN + WK_N;
   logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
   always_comb
   begin
      nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         flt_ff <= '0;
      end
      else
      begin
         s1_ff <= {wake_src, pin_in};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         flt_ff <= nxt_flt;
      end
   end
   wire [NPIN-1:0] pin_s = flt_ff[NPIN-1:0];
   wire [WK_N-1:0] wk_s = flt_ff[SW-1:NPIN];

   // ----------------------------------------
   // Register file and Avalon slave
   // ----------------------------------------
   logic [1:0] mode_ff, nxt_mode;
   logic [NP-1:0] supply_ff, nxt_supply;
   logic [NPIN-1:0] fsel_ff, nxt_fsel, ie_ff, nxt_ie, octl_ff, nxt_octl;
   logic [WK_N-1:0] wken_ff, nxt_wken;
   logic [WARMUP_W-1:0] warm_ff, nxt_warm;
   logic [1:0] osc_ff, nxt_osc;
   logic wr_ff, nxt_wr;
   logic [31:0] rd_ff, nxt_rd;
   lpm_state_t st_ff, nxt_st;
   logic [WARMUP_W-1:0] cnt_ff, nxt_cnt;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i])
            old[i*8 +: 8] = d[i*8 +: 8];
      return old;
   endfunction : merge

   logic [31:0] rmux, wv;
   always_comb
   begin
      unique case (avs_address)
         OFS_STANDBY: rmux = {30'h0, mode_ff};
         OFS_CLK_SUPPLY: rmux = 32'(supply_ff);
         OFS_PORT_FSEL: rmux = 32'(fsel_ff);
         OFS_PORT_IE: rmux = 32'(ie_ff);
         OFS_PORT_OCTL: rmux = 32'(octl_ff);
         OFS_WAKE_EN: rmux = 32'(wken_ff);
         OFS_WARMUP: rmux = 32'(warm_ff);
         OFS_OSC_CTRL: rmux = {30'h0, osc_ff};
         OFS_STATUS: rmux = {30'h0, st_ff};
         default: rmux = 32'h0;
      endcase
      wv = merge(rmux, avs_writedata, avs_byteenable);
      nxt_wr = avs_waitrequest;
      nxt_rd = rd_ff;
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
         nxt_wr = 1'b0;
         nxt_rd = avs_read ? rmux : 32'h0;
      end
      else if (!avs_waitrequest)
         nxt_wr = 1'b1;
      nxt_mode = mode_ff;
      nxt_supply = supply_ff;
      nxt_fsel = fsel_ff;
      nxt_ie = ie_ff;
      nxt_octl = octl_ff;
      nxt_wken = wken_ff;
      nxt_warm = warm_ff;
      nxt_osc = osc_ff;
      // Write lands at the edge the master sees waitrequest low
      if (avs_write && !avs_waitrequest)
      begin
         unique case (avs_address)
            // only two codes
            // Other codes are dropped so the field never holds an illegal mode
            OFS_STANDBY:
               if (wv[1:0] == MODE_LIGHT || wv[1:0] == MODE_DEEP)
                  nxt_mode = wv[1:0];
            OFS_CLK_SUPPLY: nxt_supply = wv[NP-1:0];
            OFS_PORT_FSEL: nxt_fsel = wv[NPIN-1:0];
            OFS_PORT_IE: nxt_ie = wv[NPIN-1:0];
            OFS_PORT_OCTL: nxt_octl = wv[NPIN-1:0];
            OFS_WAKE_EN: nxt_wken = wv[WK_N-1:0];
            OFS_WARMUP: nxt_warm = wv[WARMUP_W-1:0];
            OFS_OSC_CTRL: nxt_osc = wv[1:0];
            default: ;
         endcase
      end
      if (st_ff == ST_WARM)
         nxt_osc[OSC_SEL_EXT_BIT] = 1'b0;
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_ff <= MODE_LIGHT;
         supply_ff <= '0;
         fsel_ff <= '0;
         ie_ff <= '0;
         octl_ff <= '0;
         wken_ff <= WAKE_EN_RST;
         warm_ff <= WARMUP_RST;
         osc_ff <= 2'h0;
         wr_ff <= 1'b1;
         rd_ff <= 32'h0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         supply_ff <= nxt_supply;
         fsel_ff <= nxt_fsel;
         ie_ff <= nxt_ie;
         octl_ff <= nxt_octl;
         wken_ff <= nxt_wken;
         warm_ff <= nxt_warm;
         osc_ff <= nxt_osc;
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end
   assign avs_waitrequest = wr_ff;
   assign avs_readdata = rd_ff;

   // ----------------------------------------
   // Mode state machine
   // ----------------------------------------
   logic light_wake, deep_wake, rel_ff, nxt_rel;
   logic [EXT_IRQ_N-1:0] ext_ok;
   always_comb
   begin
      ext_ok = pin_s[EXT_IRQ_N-1:0] & fsel_ff[EXT_IRQ_N-1:0] & ie_ff[EXT_IRQ_N-1:0];
      light_wake = (|ext_ok) || (|(wk_s & wken_ff));
      // no watchdog or tick wake from deep stop
      // only irq pin, I2C, USB and detector wake remain
      deep_wake = (|ext_ok) || (wk_s[WK_I2C] & wken_ff[WK_I2C]) || (wk_s[WK_USB] & wken_ff[WK_USB])
                  || (wk_s[WK_LVD] & wken_ff[WK_LVD]);
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_rel = 1'b0;
      unique case (st_ff)
         ST_NORMAL:
            if (link.wfi_pulse && !link.deep_sleep_bit)
               nxt_st = (mode_ff == MODE_DEEP) ? ST_DEEP : ST_LIGHT;
         ST_LIGHT:
            if (light_wake)
            begin
               nxt_st = ST_NORMAL;
               nxt_rel = 1'b1;
            end
         ST_DEEP:
            if (deep_wake)
            begin
               nxt_st = ST_WARM;
               nxt_cnt = warm_ff;
            end
         ST_WARM:
            if (cnt_ff == '0)
            begin
               nxt_st = ST_NORMAL;
               nxt_rel = 1'b1;
            end
            else
               nxt_cnt = cnt_ff - 1'b1;
      endcase
   end
   // reset leaves deep stop without warm-up
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= ST_NORMAL;
         cnt_ff <= '0;
         rel_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         rel_ff <= nxt_rel;
      end
   end

   // ----------------------------------------
   // Clock gating and pin states
   // ----------------------------------------
   logic o_halt, o_int, o_ext, o_sel, o_xtal, o_wdt, o_lvd, o_i2c, o_usb, o_dbg;
   logic [NP-1:0] o_pclk;
   logic [NPIN-1:0] o_pin, o_oe;
   logic deep;
   always_comb
   begin
      deep = (st_ff == ST_DEEP) || (nxt_st == ST_DEEP);
      // only the core halts in light sleep
      o_halt = (nxt_st != ST_NORMAL);
      // light sleep keeps supply per enable
      // deep stop gates all but detector
      o_pclk = (deep || nxt_st == ST_WARM) ? '0 : nxt_supply;
      o_lvd = 1'b1;
      o_i2c = deep;
      o_usb = deep;
      // internal oscillator stops in deep stop
      o_int = !deep;
      o_ext = !deep && nxt_osc[OSC_EXT_EN_BIT];
      o_sel = !deep && nxt_st != ST_WARM && nxt_osc[OSC_SEL_EXT_BIT];
      o_wdt = (nxt_st != ST_LIGHT);
      // crystal pins invalid in deep stop
      o_xtal = !deep;
      // inputs gated by enable in deep stop
      o_pin = deep ? ie_ff : '1;
      // irq pins with select and enable stay valid
      // A pin left as plain port falls back to its enable, so both cases follow the enable bit
      o_pin[EXT_IRQ_N-1:0] = deep ? ((fsel_ff[EXT_IRQ_N-1:0] & ie_ff[EXT_IRQ_N-1:0])
                                     | (~fsel_ff[EXT_IRQ_N-1:0] & ie_ff[EXT_IRQ_N-1:0])) : '1;
      o_oe = ~octl_ff;
      // debug output drives only when valid
      o_dbg = !(dbg_sel && dbg_out_valid);
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         periph_clk_en <= '0;
         lvd_clk_en <= 1'b1;
         i2c_wake_en <= 1'b0;
         usb_wake_en <= 1'b0;
         int_osc_en <= 1'b1;
         ext_osc_en <= 1'b0;
         sys_clk_sel_ext <= 1'b0;
         crystal_valid <= 1'b1;
         wdt_clear_allow <= 1'b1;
         pin_in_valid <= '1;
         pin_oe_b <= '1;
         dbg_oe_b <= 1'b1;
      end
      else
      begin
         periph_clk_en <= o_pclk;
         lvd_clk_en <= o_lvd;
         i2c_wake_en <= o_i2c;
         usb_wake_en <= o_usb;
         int_osc_en <= o_int;
         ext_osc_en <= o_ext;
         sys_clk_sel_ext <= o_sel;
         crystal_valid <= o_xtal;
         wdt_clear_allow <= o_wdt;
         pin_in_valid <= o_pin;
         pin_oe_b <= o_oe;
         dbg_oe_b <= o_dbg;
      end
   end
   // Link outputs; clock source reported to the core
   logic halt_ff, clk_int_ff;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         halt_ff <= 1'b0;
         clk_int_ff <= 1'b1;
      end
      else
      begin
         halt_ff <= o_halt;
         clk_int_ff <= !o_sel;
      end
   end
   assign link.core_halt = halt_ff;
   assign link.core_release = rel_ff;
   assign link.clk_from_int = clk_int_ff;
endmodule : low_power_mode_controller

// >>> core/lpm_core_end.sv
// Core end: issues wait-for-interrupt and tracks sleep and release
`timescale 1ns/100ps
module lpm_core_end
   import lpm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   lpm_link_if.core_mp link,
   input wire logic wfi_req,
   input wire logic wfe_req,
   input wire logic deep_sleep_req,
   output logic sleeping,
   output logic woke,
   output logic refused
);
   // ----------------------------------------
   // Request handling
   // ----------------------------------------
   logic wfi_ff, nxt_wfi, slp_ff, nxt_slp, wk_ff, nxt_wk, ref_ff, nxt_ref;
   always_comb
   begin
      nxt_wfi = 1'b0;
      nxt_slp = slp_ff;
      nxt_wk = 1'b0;
      nxt_ref = wfe_req || deep_sleep_req;
      if (wfi_req && !slp_ff && !link.core_halt)
      begin
         nxt_wfi = 1'b1;
         nxt_slp = 1'b1;
      end
      else if (slp_ff && link.core_release)
      begin
         nxt_slp = 1'b0;
         nxt_wk = 1'b1;
      end
      // Held request that the device did not act on is dropped
      else if (slp_ff && !wfi_ff && !link.core_halt)
         nxt_slp = 1'b0;
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wfi_ff <= 1'b0;
         slp_ff <= 1'b0;
         wk_ff <= 1'b0;
         ref_ff <= 1'b0;
      end
      else
      begin
         wfi_ff <= nxt_wfi;
         slp_ff <= nxt_slp;
         wk_ff <= nxt_wk;
         ref_ff <= nxt_ref;
      end
   end
   assign link.wfi_pulse = wfi_ff;
   assign link.wfe_pulse = 1'b0;
   assign link.deep_sleep_bit = 1'b0;
   assign sleeping = slp_ff;
   assign woke = wk_ff;
   assign refused = ref_ff;
endmodule : lpm_core_end

// >>> core/lpm_link_if.sv
// Link between the core end and the low-power mode controller
`timescale 1ns/100ps
interface lpm_link_if;
   logic wfi_pulse;
   logic wfe_pulse;
   logic deep_sleep_bit;
   logic core_halt;
   logic core_release;
   logic clk_from_int;
   modport dev_mp (input wfi_pulse, input wfe_pulse, input deep_sleep_bit,
                   output core_halt, output core_release, output clk_from_int);
   modport core_mp (output wfi_pulse, output wfe_pulse, output deep_sleep_bit,
                    input core_halt, input core_release, input clk_from_int);
endinterface : lpm_link_if

// >>> core/lpm_pkg.sv
// Shared constants for the low-power mode controller and its core end
package lpm_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [5:0] OFS_STANDBY = 6'h00;
   localparam logic [5:0] OFS_CLK_SUPPLY = 6'h04;
   localparam logic [5:0] OFS_PORT_FSEL = 6'h08;
   localparam logic [5:0] OFS_PORT_IE = 6'h0c;
   localparam logic [5:0] OFS_PORT_OCTL = 6'h10;
   localparam logic [5:0] OFS_WAKE_EN = 6'h14;
   localparam logic [5:0] OFS_WARMUP = 6'h18;
   localparam logic [5:0] OFS_OSC_CTRL = 6'h1c;
   localparam logic [5:0] OFS_STATUS = 6'h20;
   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam logic [1:0] MODE_LIGHT = 2'h0;
   localparam logic [1:0] MODE_DEEP = 2'h1;
   localparam int OSC_EXT_EN_BIT = 0;
   localparam int OSC_SEL_EXT_BIT = 1;
   localparam int WARMUP_W = 12;
   localparam logic [11:0] WARMUP_RST = 12'h010;
   localparam int EXT_IRQ_N = 6;
   // Wake source bit positions
   localparam int WK_PERIPH = 0;
   localparam int WK_I2C = 1;
   localparam int WK_USB = 2;
   localparam int WK_LVD = 3;
   localparam int WK_WDT = 4;
   localparam int WK_SYSTICK = 5;
   localparam int WK_N = 6;
   localparam logic [WK_N-1:0] WAKE_EN_RST = 6'h08;
   typedef enum logic [1:0] {ST_NORMAL, ST_LIGHT, ST_DEEP, ST_WARM} lpm_state_t;
endpackage : lpm_pkg

// >>> verification/low_power_mode_controller_tb.sv
// Testbench joining the controller and the core end
`timescale 1ns/100ps
module low_power_mode_controller_tb;
   import lpm_pkg::*;
   localparam int NP = 12;
   localparam int NPIN = 8;
   typedef struct packed {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, dbg_sel, dbg_out_valid;
   logic [5:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [NPIN-1:0] pin_in, pin_in_valid, pin_oe_b;
   logic [WK_N-1:0] wake_src;
   logic [NP-1:0] periph_clk_en;
   logic lvd_clk_en, i2c_wake_en, usb_wake_en, int_osc_en, ext_osc_en, sys_clk_sel_ext;
   logic crystal_valid, wdt_clear_allow, dbg_oe_b, wfi_req, wfe_req, deep_sleep_req;
   logic sleeping, woke, refused;
   int mismatches = 0;
   int check_count = 0;
   row_t rows [12] = '{'{1'h0, OFS_STANDBY, 32'h0, 32'h0}, '{1'h0, OFS_WAKE_EN, 32'h0, 32'h8},
      '{1'h0, OFS_WARMUP, 32'h0, 32'h10}, '{1'h0, OFS_STATUS, 32'h0, 32'h0},
      '{1'h0, OFS_CLK_SUPPLY, 32'h0, 32'h0}, '{1'h1, OFS_STANDBY, 32'h3, 32'h0},
      '{1'h1, OFS_STANDBY, 32'h2, 32'h0}, '{1'h1, OFS_STANDBY, 32'h1, 32'h1},
      '{1'h1, OFS_STANDBY, 32'h0, 32'h0}, '{1'h1, OFS_STATUS, 32'h2, 32'h0},
      '{1'h1, 6'h3c, 32'h5, 32'h0}, '{1'h1, OFS_CLK_SUPPLY, 32'hffffffff, 32'hfff}};

   lpm_link_if lnk();
   low_power_mode_controller #(.NP(NP), .NPIN(NPIN)) i_low_power_mode_controller (.mclk, .rst_b,
      .link(lnk), .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .pin_in, .wake_src, .dbg_sel, .dbg_out_valid, .periph_clk_en, .lvd_clk_en,
      .i2c_wake_en, .usb_wake_en, .int_osc_en, .ext_osc_en, .sys_clk_sel_ext, .crystal_valid,
      .wdt_clear_allow, .pin_in_valid, .pin_oe_b, .dbg_oe_b);
   lpm_core_end i_lpm_core_end (.mclk, .rst_b, .link(lnk), .wfi_req, .wfe_req, .deep_sleep_req,
      .sleeping, .woke, .refused);
   lpm_link_chk i_lpm_link_chk (.mclk, .rst_b, .wfi_pulse(lnk.wfi_pulse), .wfe_pulse(lnk.wfe_pulse),
      .deep_sleep_bit(lnk.deep_sleep_bit), .core_halt(lnk.core_halt), .core_release(lnk.core_release),
      .clk_from_int(lnk.clk_from_int));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (n == 50)
      begin
         mismatches++;
         end_of_test();
      end
   endtask : bus

   task automatic wait_halt(input logic v, output int n);
      n = 0;
      while (lnk.core_halt !== v && n < 3000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 3000)
      begin
         mismatches++;
         end_of_test();
      end
   endtask : wait_halt

   task automatic pulse(input int k);
      @(posedge mclk);
      wfi_req <= (k == 0);
      wfe_req <= (k == 1);
      deep_sleep_req <= (k == 2);
      @(posedge mclk);
      {wfi_req, wfe_req, deep_sleep_req} <= 3'h0;
   endtask : pulse

   initial
   begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int n;
      int seen;
      logic [31:0] q;
      rst_b = 1'h0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {pin_in, wake_src, dbg_sel, dbg_out_valid, wfi_req, wfe_req, deep_sleep_req} = '0;
      repeat (5) @(posedge mclk);
      #1;
      chk({periph_clk_en, lvd_clk_en, int_osc_en, ext_osc_en, crystal_valid, pin_oe_b}, {12'h0, 4'hd, 8'hff});
      @(posedge mclk);
      rst_b <= 1'h1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            bus(1'h1, rows[i].a, rows[i].d, q);
         bus(1'h0, rows[i].a, 32'h0, q);
         chk(q, rows[i].e);
      end
      // Refused entries: event wait and core deep-sleep bit
      for (int k = 1; k < 3; k++)
      begin
         pulse(k);
         seen = 0;
         repeat (4)
         begin
            #1;
            seen += refused;
            @(posedge mclk);
         end
         chk({seen[3:0], lnk.core_halt}, 5'h2);
      end
      // Light sleep, woken by the tick
      bus(1'h1, OFS_WAKE_EN, 32'h3f, q);
      bus(1'h1, OFS_CLK_SUPPLY, 32'h00f, q);
      bus(1'h1, OFS_OSC_CTRL, 32'h3, q);
      bus(1'h1, OFS_STANDBY, {30'h0, MODE_LIGHT}, q);
      pulse(0);
      wait_halt(1'h1, n);
      @(posedge mclk);
      #1;
      chk({periph_clk_en, int_osc_en, ext_osc_en, crystal_valid, wdt_clear_allow, sleeping}, {12'h00f, 5'h1d});
      bus(1'h0, OFS_STATUS, 32'h0, q);
      chk(q, 32'h1);
      wake_src <= 6'h20;
      wait_halt(1'h0, n);
      @(posedge mclk);
      wake_src <= 6'h0;
      #1;
      chk({wdt_clear_allow, ext_osc_en, woke, sleeping}, 4'he);
      // Deep stop with pin gating; the irq pin wakes it, the tick, watchdog and peripheral sources do not
      bus(1'h1, OFS_WARMUP, 32'h40, q);
      bus(1'h1, OFS_PORT_FSEL, 32'h01, q);
      bus(1'h1, OFS_PORT_IE, 32'h05, q);
      bus(1'h1, OFS_PORT_OCTL, 32'h10, q);
      // bench runs no peripheral traffic before entry
      bus(1'h1, OFS_STANDBY, {30'h0, MODE_DEEP}, q);
      dbg_sel <= 1'h1;
      pulse(0);
      wait_halt(1'h1, n);
      @(posedge mclk);
      #1;
      chk({periph_clk_en, lvd_clk_en, int_osc_en, ext_osc_en, crystal_valid, i2c_wake_en, usb_wake_en},
         {12'h0, 6'h23});
      chk({pin_in_valid, pin_oe_b, dbg_oe_b}, {8'h05, 8'hef, 1'h1});
      @(posedge mclk);
      wake_src <= 6'h31;
      dbg_out_valid <= 1'h1;
      repeat (20) @(posedge mclk);
      #1;
      chk({lnk.core_halt, dbg_oe_b}, 2'h2);
      @(posedge mclk);
      wake_src <= 6'h0;
      pin_in <= 8'h01;
      wait_halt(1'h1, n);
      n = 0;
      while (int_osc_en !== 1'h1 && n < 100)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk({lnk.core_halt, periph_clk_en}, {1'h1, 12'h0});
      wait_halt(1'h0, n);
      // Warm-up of 0x40 with one cycle of slack below and three above
      chk({31'h0, n >= 63 && n <= 67}, 32'h1);
      @(posedge mclk);
      pin_in <= 8'h0;
      #1;
      chk({sys_clk_sel_ext, lnk.clk_from_int, periph_clk_en}, {2'h1, 12'h00f});
      // Reset releases deep stop at once, with no warm-up
      // Let the irq pin clear the synchroniser first, or it wakes the part at once
      repeat (4) @(posedge mclk);
      pulse(0);
      wait_halt(1'h1, n);
      chk(int_osc_en, 1'h0);
      @(posedge mclk);
      rst_b <= 1'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk({lnk.core_halt, int_osc_en, lnk.clk_from_int}, 3'h3);
      @(posedge mclk);
      rst_b <= 1'h1;
      bus(1'h0, OFS_STANDBY, 32'h0, q);
      chk(q, 32'h0);
      end_of_test();
   end
endmodule : low_power_mode_controller_tb

// >>> verification/lpm_link_chk.sv
// Concurrent checks on the link between the core end and the controller
`timescale 1ns/100ps
module lpm_link_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wfi_pulse,
   input wire logic wfe_pulse,
   input wire logic deep_sleep_bit,
   input wire logic core_halt,
   input wire logic core_release,
   input wire logic clk_from_int
);
   // ----------------------------------------
   // Link assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   halt_entry_a: assert property (wfi_pulse && !core_halt && !deep_sleep_bit |=> core_halt)
      else $error("core not halted after wait-for-interrupt");
   halt_cause_a: assert property ($rose(core_halt) |-> $past(wfi_pulse))
      else $error("core halted without wait-for-interrupt");
   // Event wake is not offered, so the event line must stay quiet
   wfe_quiet_a: assert property (!wfe_pulse)
      else $error("wait-for-event issued");
   deep_bit_low_a: assert property (!deep_sleep_bit)
      else $error("core deep-sleep bit set");
   release_fell_a: assert property ($fell(core_halt) |-> core_release)
      else $error("halt dropped without release pulse");
   release_pulse_a: assert property (core_release |-> $past(core_halt) && !core_halt ##1 !core_release)
      else $error("release pulse malformed");
   clk_int_reset_a: assert property ($rose(rst_b) |-> clk_from_int)
      else $error("system clock not internal after reset");
   wfi_single_a: assert property (wfi_pulse |=> !wfi_pulse)
      else $error("wait-for-interrupt pulse too long");
endmodule : lpm_link_chk
